// ===== bert_pkg.sv
// Register map, field layouts and fixed counts of the BERT control block.
// Assumes a byte-wide register port and one 25 MHz system clock.
package bert_pkg;

  // Register offsets on the byte port.
  localparam logic [7:0] ADDR_STATUS  = 8'h26;
  localparam logic [7:0] ADDR_MASK    = 8'h27;
  localparam logic [7:0] ADDR_WORDCNT = 8'hDB;
  localparam logic [7:0] ADDR_CTL_ONE = 8'hE0;
  localparam logic [7:0] ADDR_CTL_TWO = 8'hE1;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  // Pattern selections and bit counts.
  localparam logic [2:0] SEL_REPEAT = 3'h4;
  localparam logic [2:0] SEL_ALT    = 3'h5;
  localparam logic [5:0] LEN_BASE   = 6'h11;
  localparam logic [5:0] ALT_BITS   = 6'h10;
  localparam logic [5:0] FULL_BITS  = 6'h20;
  localparam logic [5:0] SYNC_BITS  = 6'h20;
  localparam logic [5:0] RUN_BITS   = 6'h20;
  localparam logic [2:0] LOS_ERRS   = 3'h6;

  // Status bit positions; the first four are conditions.
  localparam int FLG_SYNC  = 0;
  localparam int FLG_LOST  = 1;
  localparam int FLG_ECNT  = 4;
  localparam int FLG_BCNT  = 5;
  localparam int FLG_BERR  = 6;
  localparam logic [3:0] COND_RST = 4'h2;

  // Bits between automatic errors, per rate code.
  localparam logic [23:0] RATE_PERIOD [8] = '{
    24'h000000, 24'h00000A, 24'h000064, 24'h0003E8,
    24'h002710, 24'h0186A0, 24'h0F4240, 24'h989680};

  typedef struct packed {
    logic       load;
    logic       tx_inv;
    logic       rx_inv;
    logic [2:0] sel;
    logic       lc;
    logic       resync;
  } ctl_one_t;

  typedef struct packed {
    logic [2:0] rate;
    logic       single;
    logic [3:0] len;
  } ctl_two_t;

endpackage

// ===== bert_rise.sv
// Rising-edge detector for write-triggered control bits.
// Assumes the old value is the stored register before the write.
module bert_rise #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_wr,
  input  wire logic [W-1:0] i_old,
  input  wire logic [W-1:0] i_new,
  output logic      [W-1:0] o_pulse
);

  logic [W-1:0] pulse_next;

  // Only a written zero-to-one change makes a one-clock pulse.
  assign pulse_next = i_wr ? (i_new & ~i_old) : '0;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) o_pulse <= '0;
    else o_pulse <= pulse_next;
  end

  AST_RISE_CAUSE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_pulse != '0) |-> $past(i_wr) && (($past(i_old) & o_pulse) == '0)
  ) else $error("Pulse without a written rising bit.");

endmodule

// ===== bert_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock; depth must be a power of two.
module bert_fifo #(
  parameter int W     = 1,
  parameter int DEPTH = 32
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic      [W-1:0] o_out_data,
  input  wire logic         i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
      $error("FIFO depth must be a power of two, width at least one.");
    end
  endgenerate

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  logic         push;
  logic         pop;

  // Full when pointers differ only in the wrap bit.
  assign o_in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_clk_sys) begin
    if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end

  AST_FIFO_LEVEL: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (AW+1)'(wr_ptr_reg - rd_ptr_reg) <= (AW+1)'(DEPTH)
  ) else $error("FIFO level beyond its depth.");

endmodule

// ===== bert_ctrl.sv
// BERT generator, detector and status block behind the byte port.
// Assumes rx bits and tx ready come from logic on the system clock.
module bert_ctrl #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  output logic      [7:0]  o_rdata,
  input  wire logic [31:0] i_pattern,
  output logic             o_tx_valid,
  output logic             o_tx_bit,
  input  wire logic        i_tx_ready,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_bit,
  output logic             o_rx_in_sync,
  output logic             o_int_req
);

  bert_pkg::ctl_one_t ctl1_reg;
  bert_pkg::ctl_two_t ctl2_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  wcnt_reg;
  logic [6:0]  flags_reg;
  logic [6:0]  pend_reg;
  logic [3:0]  cond_prev_reg;
  logic [31:0] gen_word_reg;
  logic [4:0]  gen_idx_reg;
  logic        gen_on_reg;
  logic        alt_sel_reg;
  logic [7:0]  alt_rep_reg;
  logic        err_pend_reg;
  logic [23:0] rate_cnt_reg;
  logic [31:0] hist_reg;
  logic        sync_reg;
  logic [5:0]  match_reg;
  logic [2:0]  errs_reg;
  logic [5:0]  zeros_reg;
  logic [5:0]  ones_reg;
  logic [31:0] bit_cnt_reg;
  logic [23:0] err_cnt_reg;
  logic        fifo_ready;

  // Register port decode.
  wire wr_ctl1   = i_wr_stb && i_addr == bert_pkg::ADDR_CTL_ONE;
  wire wr_ctl2   = i_wr_stb && i_addr == bert_pkg::ADDR_CTL_TWO;
  wire wr_mask   = i_wr_stb && i_addr == bert_pkg::ADDR_MASK;
  wire wr_wcnt   = i_wr_stb && i_addr == bert_pkg::ADDR_WORDCNT;
  wire rd_status = i_rd_stb && i_addr == bert_pkg::ADDR_STATUS;

  // Read data mux; unmapped offsets read as zero.
  wire [7:0] rd_mux =
    (i_addr == bert_pkg::ADDR_STATUS)  ? {1'b0, flags_reg} :
    (i_addr == bert_pkg::ADDR_MASK)    ? {1'b0, mask_reg[6:0]} :
    (i_addr == bert_pkg::ADDR_WORDCNT) ? wcnt_reg :
    (i_addr == bert_pkg::ADDR_CTL_ONE) ? 8'(ctl1_reg) :
    (i_addr == bert_pkg::ADDR_CTL_TWO) ? 8'(ctl2_reg) : 8'h00;

  // Writes and registered read data.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctl1_reg <= bert_pkg::ctl_one_t'(bert_pkg::RST_BYTE);
      ctl2_reg <= bert_pkg::ctl_two_t'(bert_pkg::RST_BYTE);
      mask_reg <= bert_pkg::RST_BYTE;
      wcnt_reg <= bert_pkg::RST_BYTE;
      o_rdata  <= bert_pkg::RST_BYTE;
    end else begin
      if (wr_ctl1) ctl1_reg <= bert_pkg::ctl_one_t'(i_wdata);
      if (wr_ctl2) ctl2_reg <= bert_pkg::ctl_two_t'(i_wdata);
      if (wr_mask) mask_reg <= i_wdata;
      if (wr_wcnt) wcnt_reg <= i_wdata;
      if (i_rd_stb) o_rdata <= rd_mux;
    end
  end

  // Write-triggered action pulses.
  logic [1:0] ctl1_pulse;
  logic       single_pulse;
  wire        load_pulse   = ctl1_pulse[1];
  wire        resync_pulse = ctl1_pulse[0];

  bert_rise #(.W(2)) u_rise_one (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_wr      (wr_ctl1),
    .i_old     ({ctl1_reg.load, ctl1_reg.resync}),
    .i_new     ({i_wdata[7], i_wdata[0]}),
    .o_pulse   (ctl1_pulse)
  );

  bert_rise #(.W(1)) u_rise_two (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_wr      (wr_ctl2),
    .i_old     (ctl2_reg.single),
    .i_new     (i_wdata[4]),
    .o_pulse   (single_pulse)
  );

  // Pattern length: repeating uses the code, pseudorandom ignores it.
  wire is_rep = ctl1_reg.sel == bert_pkg::SEL_REPEAT;
  wire is_alt = ctl1_reg.sel == bert_pkg::SEL_ALT;
  wire [5:0] rep_len = bert_pkg::LEN_BASE + {2'b00, ctl2_reg.len};
  wire [5:0] len_bits = is_rep ? rep_len :
    is_alt ? bert_pkg::ALT_BITS : bert_pkg::FULL_BITS;
  wire [4:0] last_idx = 5'(len_bits - 6'h01);

  // Generator tap, error insertion and inversion.
  wire       gen_step = gen_on_reg & fifo_ready;
  wire       gen_last = gen_idx_reg == last_idx;
  wire [4:0] gen_tap  = is_alt ? {alt_sel_reg, gen_idx_reg[3:0]}
                               : gen_idx_reg;
  wire [23:0] period  = bert_pkg::RATE_PERIOD[ctl2_reg.rate];
  wire rate_hit = ctl2_reg.rate != 3'h0 &&
                  rate_cnt_reg == 24'(period - 24'h000001);
  wire err_now  = err_pend_reg | rate_hit;
  wire gen_bit  = gen_word_reg[gen_tap] ^ err_now ^ ctl1_reg.tx_inv;

  // Generator sequencing.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gen_on_reg   <= 1'b0;
      gen_word_reg <= '0;
      gen_idx_reg  <= '0;
      alt_sel_reg  <= 1'b0;
      alt_rep_reg  <= '0;
    end else if (load_pulse) begin
      gen_on_reg   <= 1'b1;
      gen_word_reg <= i_pattern;
      gen_idx_reg  <= '0;
      alt_sel_reg  <= 1'b0;
      alt_rep_reg  <= 8'(wcnt_reg - 8'h01);
    end else if (gen_step) begin
      gen_idx_reg <= gen_last ? 5'h00 : 5'(gen_idx_reg + 5'h01);
      if (gen_last && is_alt) begin
        alt_sel_reg <= alt_sel_reg ^ (alt_rep_reg == 8'h00);
        alt_rep_reg <= (alt_rep_reg == 8'h00)
                     ? 8'(wcnt_reg - 8'h01) : 8'(alt_rep_reg - 8'h01);
      end
    end
  end

  // Error pending and rate counter; a new request wins over the use.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      err_pend_reg <= 1'b0;
      rate_cnt_reg <= '0;
    end else begin
      err_pend_reg <= single_pulse | (err_pend_reg & ~gen_step);
      if (ctl2_reg.rate == 3'h0 || (gen_step && rate_hit))
        rate_cnt_reg <= '0;
      else if (gen_step)
        rate_cnt_reg <= 24'(rate_cnt_reg + 24'h000001);
    end
  end

  // Outgoing bits wait in the FIFO; a full FIFO stalls the generator.
  bert_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_in_valid  (gen_on_reg),
    .i_in_data   (gen_bit),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_tx_valid),
    .o_out_data  (o_tx_bit),
    .i_out_ready (i_tx_ready)
  );

  // Detector: in sync the history flywheels on its own prediction.
  wire rx_bit   = i_rx_bit ^ ctl1_reg.rx_inv;
  wire expect_b = hist_reg[last_idx];
  wire miss     = rx_bit != expect_b;
  wire gain     = !sync_reg && !miss &&
                  match_reg == 6'(bert_pkg::SYNC_BITS - 6'h01);
  wire drop     = sync_reg && miss && errs_reg == 3'(bert_pkg::LOS_ERRS - 3'h1);
  wire go_sync  = i_rx_valid && gain && !resync_pulse;
  wire search_start = resync_pulse || (i_rx_valid && drop);
  wire counting = i_rx_valid && sync_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hist_reg  <= '0;
      sync_reg  <= 1'b0;
      match_reg <= '0;
      errs_reg  <= '0;
    end else if (search_start) begin
      sync_reg  <= 1'b0;
      match_reg <= '0;
      errs_reg  <= '0;
      if (i_rx_valid) hist_reg <= {hist_reg[30:0], rx_bit};
    end else if (i_rx_valid) begin
      hist_reg <= {hist_reg[30:0], sync_reg ? expect_b : rx_bit};
      if (go_sync) sync_reg <= 1'b1;
      if (miss && !sync_reg) match_reg <= '0;
      else if (match_reg == bert_pkg::SYNC_BITS - 6'h01) match_reg <= '0;
      else if (!miss) match_reg <= 6'(match_reg + 6'h01);
      if (sync_reg && miss) errs_reg <= 3'(errs_reg + 3'h1);
      else if (sync_reg && match_reg == 6'h1F) errs_reg <= '0;
    end
  end

  // Runs of equal bits, saturating at the latch count.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      zeros_reg <= '0;
      ones_reg  <= '0;
    end else if (i_rx_valid) begin
      if (rx_bit) zeros_reg <= '0;
      else if (zeros_reg != bert_pkg::RUN_BITS)
        zeros_reg <= 6'(zeros_reg + 6'h01);
      if (!rx_bit) ones_reg <= '0;
      else if (ones_reg != bert_pkg::RUN_BITS)
        ones_reg <= 6'(ones_reg + 6'h01);
    end
  end

  // Bit and error counters run only in sync and saturate.
  wire bcnt_ovf = counting && bit_cnt_reg == 32'hFFFFFFFE;
  wire ecnt_ovf = counting && miss && err_cnt_reg == 24'hFFFFFE;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bit_cnt_reg <= '0;
      err_cnt_reg <= '0;
    end else begin
      if (counting && bit_cnt_reg != 32'hFFFFFFFF)
        bit_cnt_reg <= 32'(bit_cnt_reg + 32'h00000001);
      if (counting && miss && err_cnt_reg != 24'hFFFFFF)
        err_cnt_reg <= 24'(err_cnt_reg + 24'h000001);
    end
  end

  // Status: conditions clear on read only once gone; set wins over read.
  wire [3:0] cond  = {ones_reg == bert_pkg::RUN_BITS,
                      zeros_reg == bert_pkg::RUN_BITS,
                      !sync_reg, sync_reg};
  wire [6:0] set_v = {counting && miss, bcnt_ovf, ecnt_ovf,
                      cond[3], cond[2], search_start, cond[0]};
  wire [6:0] hold  = {3'b000, cond};
  wire [6:0] ev    = {set_v[6:4], cond ^ cond_prev_reg};

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      flags_reg     <= '0;
      pend_reg      <= '0;
      cond_prev_reg <= bert_pkg::COND_RST;
    end else begin
      flags_reg <= set_v | (flags_reg & ~({7{rd_status}} & ~hold));
      pend_reg  <= ev | (pend_reg & ~{7{rd_status}});
      cond_prev_reg <= cond;
    end
  end

  // Interrupt request gated by the mask bits.
  assign o_int_req    = |(pend_reg & mask_reg[6:0]);
  assign o_rx_in_sync = sync_reg;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_load_then_step;
    load_pulse ##1 (gen_step && !err_now);
  endsequence

  AST_INVERT_FIRST: assert property (
    s_load_then_step |-> gen_bit == (gen_word_reg[0] ^ ctl1_reg.tx_inv)
  ) else $error("First bit after load not pattern bit zero.");

  AST_LOAD_TAKES: assert property (
    load_pulse |=> gen_idx_reg == 5'h00 && gen_word_reg == $past(i_pattern)
  ) else $error("Pattern load did not restart the generator.");

  AST_REP_WRAP: assert property (
    (is_rep && gen_step && !load_pulse && gen_idx_reg == 5'(rep_len - 6'h01))
    |=> gen_idx_reg == 5'h00
  ) else $error("Repeating pattern did not wrap at its length.");

  AST_PRBS_LEN: assert property (
    (!is_rep && !is_alt && gen_step && !load_pulse && gen_idx_reg == 5'h10)
    |=> gen_idx_reg == 5'h11
  ) else $error("Pseudorandom length followed the length code.");

  AST_SINGLE_ONCE: assert property (
    (err_pend_reg && gen_step && !single_pulse) |=> !err_pend_reg
  ) else $error("Single error used more than once.");

  AST_ALT_FLIP: assert property (
    $changed(alt_sel_reg) |-> $past(load_pulse) ||
      ($past(alt_rep_reg) == 8'h00 && $past(gen_last) && $past(gen_step))
  ) else $error("Alternating word flipped early.");

  AST_SYNC_GAIN: assert property (
    go_sync |=> (sync_reg && o_rx_in_sync) ##1 flags_reg[bert_pkg::FLG_SYNC]
  ) else $error("Sync not reported after matching run.");

  AST_LOST_HOLD: assert property (
    search_start |=> flags_reg[bert_pkg::FLG_LOST] [*2]
  ) else $error("Loss of sync flag not held.");

  AST_ZERO_RELEASE: assert property (
    $fell(flags_reg[2]) |-> $past(zeros_reg) != bert_pkg::RUN_BITS
  ) else $error("All-zeros flag cleared while zeros persist.");

  AST_ONES_RELEASE: assert property (
    $fell(flags_reg[3]) |-> $past(ones_reg) != bert_pkg::RUN_BITS
  ) else $error("All-ones flag cleared while ones persist.");

  AST_ECNT_READ: assert property (
    (rd_status && !ecnt_ovf) |=> !flags_reg[bert_pkg::FLG_ECNT]
  ) else $error("Error overflow flag survived a status read.");

  AST_BERR_SYNC: assert property (
    $rose(flags_reg[bert_pkg::FLG_BERR]) |-> $past(sync_reg)
  ) else $error("Bit error flagged out of sync.");

  AST_MASKED_QUIET: assert property (
    (mask_reg[6:0] == 7'h00) |-> !o_int_req
  ) else $error("Interrupt raised with every source masked.");

  AST_BCNT_SAT: assert property (
    (bit_cnt_reg == 32'hFFFFFFFF) |=> bit_cnt_reg == 32'hFFFFFFFF
  ) else $error("Bit counter wrapped past full scale.");

endmodule

// ===== bert_line_peer.sv
// Line-side peer of the BERT block: takes generated bits, loops them back.
// Assumes the tx and rx streams of the block share the system clock.
module bert_line_peer (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_stall,
  input  wire logic i_tx_valid,
  input  wire logic i_tx_bit,
  output logic      o_tx_ready,
  output logic      o_rx_valid,
  output logic      o_rx_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line refuses bits while the bench asks it to stall.
  assign o_tx_ready = ~i_stall;

  // Each taken bit returns for one cycle; between bits the data line toggles
  // so a stale value is never mistaken for a real received bit.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rx_valid <= 1'b0;
      o_rx_bit   <= 1'b0;
    end else if (i_tx_valid && o_tx_ready) begin
      o_rx_valid <= 1'b1;
      o_rx_bit   <= i_tx_bit;
    end else begin
      o_rx_valid <= 1'b0;
      o_rx_bit   <= ~o_rx_bit;
    end
  end
endmodule

// ===== bert_ctrl_test.sv
// Self-checking bench of the BERT block over its byte register port.
// Assumes the line peer loops every generated bit back into the receiver.
module bert_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk_sys, i_rst, i_wr_stb, i_rd_stb, stall;
  logic [7:0]  i_addr, i_wdata, rdata, got;
  logic [31:0] i_pattern;
  logic        tx_valid, tx_bit, tx_ready, rx_valid, rx_bit, in_sync, irq;
  int          mismatches, checked;
  logic        q[$];

  bert_ctrl uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .o_rdata(rdata), .i_pattern(i_pattern), .o_tx_valid(tx_valid),
    .o_tx_bit(tx_bit), .i_tx_ready(tx_ready), .i_rx_valid(rx_valid),
    .i_rx_bit(rx_bit), .o_rx_in_sync(in_sync), .o_int_req(irq));

  bert_line_peer peer (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_stall(stall), .i_tx_valid(tx_valid), .i_tx_bit(tx_bit),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_bit(rx_bit));

  // Clock of 40 ns period.
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // Every bit looped back by the peer is recorded in arrival order.
  always @(posedge i_clk_sys) begin
    if (rx_valid === 1'b1) q.push_back(rx_bit);
  end

  // Compares a seen value with the expected one and counts the outcome.
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A write is one strobe cycle followed by an idle cycle.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr_stb = 1'b1;
    @(posedge i_clk_sys) #1 i_wr_stb = 1'b0;
    @(posedge i_clk_sys) #1;
  endtask

  // A read returns data in the cycle after the strobe.
  task automatic rd(logic [7:0] a);
    i_addr = a;
    i_rd_stb = 1'b1;
    @(posedge i_clk_sys) #1 i_rd_stb = 1'b0;
    got = rdata;
    @(posedge i_clk_sys) #1;
  endtask

  // Resets the block, then programs pattern, control two and control one.
  task automatic start(logic [31:0] p, logic [7:0] c1, logic [7:0] c2,
                       logic s);
    i_rst = 1'b1;
    stall = s;
    i_pattern = p;
    repeat (5) @(posedge i_clk_sys);
    #1 i_rst = 1'b0;
    q.delete();
    wr(bert_pkg::ADDR_CTL_TWO, c2);
    wr(bert_pkg::ADDR_CTL_ONE, c1);
  endtask

  // Waits, bounded, until n looped-back bits are recorded.
  task automatic take(int n);
    int k;
    k = 0;
    while (q.size() < n && k < 4 * n + 100) begin
      @(posedge i_clk_sys) #1;
      k++;
    end
    check("bits taken", q.size() >= n, 1);
  endtask

  // Counts ones among n recorded bits starting at index f.
  function automatic int ones(int f, int n);
    int s;
    s = 0;
    for (int i = f; i < f + n; i++) s += int'(q[i]);
    return s;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    mismatches++;
    conclude();
  end

  // Main sequence of tests.
  initial begin
    logic [7:0]  adr [4];
    logic [31:0] pat;
    int          len;
    logic [5:0]  p6;
    adr = '{8'h26, 8'h27, 8'hDB, 8'hE1};
    i_rst = 1'b1;
    i_wr_stb = 1'b0;
    i_rd_stb = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_pattern = 32'h0;
    stall = 1'b0;
    @(posedge i_clk_sys) #1;

    // Reset values, access kinds and an unmapped address.
    start(32'h0, 8'h00, 8'h00, 1'b0);
    foreach (adr[i]) begin
      rd(adr[i]);
      check("reset value", got, 8'h00);
    end
    wr(8'h26, 8'hFF);
    rd(8'h26);
    check("status after write", got, 8'h00);
    wr(bert_pkg::ADDR_MASK, 8'hFF);
    rd(bert_pkg::ADDR_MASK);
    check("mask readback", got, 8'h7F);
    wr(bert_pkg::ADDR_WORDCNT, 8'hA5);
    rd(bert_pkg::ADDR_WORDCNT);
    check("word count readback", got, 8'hA5);
    wr(8'h55, 8'h3C);
    rd(8'h55);
    check("unmapped read", got, 8'h00);
    $display("test registers done");

    // Repeating pattern at both length limits, buffered while stalled.
    pat = 32'hB4C3_96A7;
    for (int c = 0; c < 16; c += 15) begin
      len = c + 17;
      start(pat, 8'h90, 8'(c), 1'b1);
      wr(bert_pkg::ADDR_MASK, 8'h01);
      repeat (60) @(posedge i_clk_sys);
      #1 check("valid while stalled", tx_valid, 1'b1);
      check("nothing passes a stall", q.size(), 0);
      stall = 1'b0;
      take(len + 40);
      for (int i = 0; i < len + 40; i++) begin
        check("repeat bit", q[i], pat[i % len]);
      end
      repeat (3) @(posedge i_clk_sys) #1;
      check("live sync", in_sync, 1'b1);
      check("sync interrupt", irq, 1'b1);
      rd(bert_pkg::ADDR_STATUS);
      check("sync flag", got & 8'h01, 8'h01);
      check("interrupt after read", irq, 1'b0);
    end
    // Pseudorandom select keeps 32 bits whatever the length code says.
    start(pat, 8'h80, 8'h00, 1'b0);
    take(72);
    for (int i = 0; i < 72; i++) begin
      check("full length bit", q[i], pat[i % 32]);
    end
    check("sync before resync", in_sync, 1'b1);
    // A rise of the resync bit restarts the search and latches loss.
    wr(bert_pkg::ADDR_CTL_ONE, 8'h81);
    check("resync drops sync", in_sync, 1'b0);
    rd(bert_pkg::ADDR_STATUS);
    check("loss flag", got & 8'h02, 8'h02);
    // A six-bit pattern spread over an eighteen-bit length.
    p6 = 6'h16;
    for (int i = 0; i < 32; i++) pat[i] = p6[i % 6];
    start(pat, 8'h90, 8'h01, 1'b0);
    take(60);
    for (int i = 0; i < 60; i++) begin
      check("short pattern bit", q[i], p6[i % 6]);
    end
    $display("test repeating done");

    // Inverted zero pattern gives all ones; plain gives all zeros.
    start(32'h0, 8'hD0, 8'h00, 1'b0);
    take(64);
    check("inverted ones", ones(0, 64), 64);
    rd(bert_pkg::ADDR_STATUS);
    check("all ones flag", got & 8'h0C, 8'h08);
    wr(bert_pkg::ADDR_CTL_ONE, 8'h90);
    q.delete();
    take(96);
    check("plain zeros", ones(40, 56), 0);
    rd(bert_pkg::ADDR_STATUS);
    rd(bert_pkg::ADDR_STATUS);
    check("all zeros flag", got & 8'h0C, 8'h04);
    $display("test inversion done");

    // Single error: one per rise of the insert bit only.
    rd(bert_pkg::ADDR_STATUS);
    q.delete();
    wr(bert_pkg::ADDR_CTL_TWO, 8'h10);
    take(96);
    check("single error", ones(0, 96), 1);
    rd(bert_pkg::ADDR_STATUS);
    check("bit error flag", got & 8'h40, 8'h40);
    rd(bert_pkg::ADDR_STATUS);
    check("bit error cleared", got & 8'h40, 8'h00);
    q.delete();
    wr(bert_pkg::ADDR_CTL_TWO, 8'h10);
    take(96);
    check("no rise no error", ones(0, 96), 0);
    wr(bert_pkg::ADDR_CTL_TWO, 8'h00);
    q.delete();
    wr(bert_pkg::ADDR_CTL_TWO, 8'h10);
    take(96);
    check("second single error", ones(0, 96), 1);
    $display("test single error done");

    // Automatic errors at one in ten.
    q.delete();
    wr(bert_pkg::ADDR_CTL_TWO, 8'h20);
    take(240);
    check("auto error count", ones(40, 200), 20);
    $display("test auto error done");

    // Alternating words, each repeated twice.
    start(32'hFFFF_0000, 8'h00, 8'h00, 1'b0);
    wr(bert_pkg::ADDR_WORDCNT, 8'h02);
    q.delete();
    wr(bert_pkg::ADDR_CTL_ONE, 8'h94);
    take(128);
    for (int i = 0; i < 128; i++) begin
      check("alternating bit", q[i], (i / 32) % 2);
    end
    $display("test alternating done");
    conclude();
  end
endmodule
